// >>> hw/csfm_defs.svh
`ifndef CSFM_DEFS_SVH
`define CSFM_DEFS_SVH

// device numbers claimed on the socket bus
`define CSFM_DEV_UNCORE   5'h00
`define CSFM_DEV_LINK     5'h02
`define CSFM_DEV_MC       5'h03
`define CSFM_DEV_CH0      5'h04
`define CSFM_DEV_CH2      5'h06
// link functions
`define CSFM_FN_L1_PROT   3'h4
`define CSFM_FN_L1_PHY    3'h5
// memory controller functions
`define CSFM_FN_MC_RAS    3'h2
`define CSFM_FN_MC_TEST   3'h4
// vendor-private dword window inside every function
`define CSFM_PRIV_LO      6'h38
`define CSFM_PRIV_HI      6'h3f
// scratch dword implemented in every function
`define CSFM_SCRATCH_IDX  6'h10
`define CSFM_SCRATCH_RST  32'h0000_0000
// sticky status dword
`define CSFM_STICKY_IDX   6'h11
`define CSFM_STICKY_RST   32'h0000_0000
// private read pattern
`define CSFM_PRIV_VALUE   32'h5a5a_0000
// number of functions with storage
`define CSFM_NFUNC        22

`endif

// >>> hw/csfm_pkg.sv
package csfm_pkg;
	// access phase of the configuration responder
	typedef enum logic [1:0] {
		CSFM_IDLE,
		CSFM_RESP
	} csfm_state_type;
endpackage : csfm_pkg

// >>> hw/csfm_func_decode.sv
`timescale 1ns/1ps
`include "csfm_defs.svh"

// maps device and function to a storage slot, or reports absent
module csfm_func_decode
(
	// target
	input  wire logic [4:0] dev_i,
	input  wire logic [2:0] fn_i,
	// part options
	input  wire logic       two_links_i,
	input  wire logic       rdimm_i,
	// result
	output logic            hit_o,
	output logic [4:0]      slot_o
);
	// slot numbering: 0-1 uncore, 2-5 links, 6-9 mc, 10-21 channels
	always_comb
	begin
		hit_o  = 1'b0;
		slot_o = 5'h00;
		case (dev_i)
			`CSFM_DEV_UNCORE:
			begin
				hit_o  = (fn_i <= 3'h1);
				slot_o = {4'h0, fn_i[0]};
			end
			`CSFM_DEV_LINK:
			begin
				// second link only on two-link parts
				if (fn_i <= 3'h1)
				begin
					hit_o  = 1'b1;
					slot_o = 5'h02 + {4'h0, fn_i[0]};
				end
				else if (fn_i == `CSFM_FN_L1_PROT || fn_i == `CSFM_FN_L1_PHY)
				begin
					hit_o  = two_links_i;
					slot_o = 5'h04 + {4'h0, fn_i[0]};
				end
			end
			`CSFM_DEV_MC:
			begin
				if (fn_i <= 3'h1)
				begin
					hit_o  = 1'b1;
					slot_o = 5'h06 + {4'h0, fn_i[0]};
				end
				else if (fn_i == `CSFM_FN_MC_RAS)
				begin
					hit_o  = rdimm_i;
					slot_o = 5'h08;
				end
				else if (fn_i == `CSFM_FN_MC_TEST)
				begin
					hit_o  = 1'b1;
					slot_o = 5'h09;
				end
			end
			default:
			begin
				// three channel devices, four functions each
				if (dev_i >= `CSFM_DEV_CH0 && dev_i <= `CSFM_DEV_CH2
					&& fn_i <= 3'h3)
				begin
					hit_o  = 1'b1;
					slot_o = 5'h0a + {dev_i[2:0] - 3'h4, 2'h0}
						+ {3'h0, fn_i[1:0]};
				end
			end
		endcase
	end
endmodule : csfm_func_decode

// >>> hw/csfm_config_space.sv
`timescale 1ns/1ps
`include "csfm_defs.svh"

// Summary of operation
// - reserved locations complete normally, never hang
// - reserved reads return zero at any width
// - reserved writes are dropped, no state changes
// - vendor-private reads may return nonzero
// - reset loads defaults, some from straps
// - sticky bits survive hard reset, clear on power-good
// - six devices answer on the socket bus
// - bus number from max range and socket
// - device 0: uncore and address decode functions
// - device 2: link functions 0,1,4,5
// - device 3: memory controller functions 0,1,2,4
// - devices 4-6: channel functions 0 to 3
module csfm_config_space
(
	// clock and resets
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        power_good_reset_i,
	// straps and part options
	input  wire logic [1:0]  max_bus_range_i,
	input  wire logic [2:0]  socket_id_i,
	input  wire logic [31:0] scratch_strap_i,
	input  wire logic        two_links_i,
	input  wire logic        rdimm_i,
	// configuration request
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  bus_i,
	input  wire logic [4:0]  dev_i,
	input  wire logic [2:0]  fn_i,
	input  wire logic [5:0]  dw_i,
	input  wire logic [3:0]  be_i,
	input  wire logic [31:0] wdata_i,
	// configuration answer
	output logic             done_o,
	output logic             claim_o,
	output logic [31:0]      rdata_o,
	// status
	output logic [7:0]       bus_num_o,
	output logic [31:0]      sticky_status_o
);
	// storage: one scratch and one sticky dword per function
	logic [31:0] scratch_q [`CSFM_NFUNC];
	logic [31:0] scratch_d [`CSFM_NFUNC];
	logic [31:0] sticky_q  [`CSFM_NFUNC];
	logic [31:0] sticky_d  [`CSFM_NFUNC];
	logic        strap_load_q; // defaults from straps once after reset
	logic        strap_load_d;
	// answer path
	csfm_pkg::csfm_state_type state_q;
	csfm_pkg::csfm_state_type state_d;
	logic        done_q, done_d;
	logic        claim_q, claim_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0]  bus_q, bus_d;
	logic [31:0] stat_q, stat_d;
	// decode result
	logic        fn_hit;
	logic [4:0]  slot;
	logic        bus_hit;

	// merge write data by byte enable
	function automatic logic [31:0] merge_be(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge_be

	// socket bus: ff minus the range bits placed above the socket bits
	function automatic logic [7:0] sock_bus(input logic [1:0] rng,
		input logic [2:0] sock);
		return 8'hff - {3'h0, rng, sock};
	endfunction : sock_bus

	csfm_func_decode u_decode
	(
		.dev_i       (dev_i),
		.fn_i        (fn_i),
		.two_links_i (two_links_i),
		.rdimm_i     (rdimm_i),
		.hit_o       (fn_hit),
		.slot_o      (slot)
	);

	// only the socket's own bus is decoded
	assign bus_hit = (bus_i == bus_q);

	// next values of the responder and storage
	always_comb
	begin
		state_d      = state_q;
		done_d       = 1'b0;
		claim_d      = 1'b0;
		rdata_d      = rdata_q;
		strap_load_d = 1'b0;
		bus_d        = sock_bus(max_bus_range_i, socket_id_i);
		scratch_d    = scratch_q;
		sticky_d     = sticky_q;
		stat_d       = stat_q;
		// straps sampled by a clocked load after reset release
		if (strap_load_q)
			for (int i = 0; i < `CSFM_NFUNC; i++)
				scratch_d[i] = scratch_strap_i;
		case (state_q)
			csfm_pkg::CSFM_IDLE:
			begin
				if (req_i)
				begin
					// every cycle is answered one cycle later
					state_d = csfm_pkg::CSFM_RESP;
					done_d  = 1'b1;
					claim_d = bus_hit && fn_hit;
					rdata_d = 32'h0000_0000;
					if (bus_hit && fn_hit && !we_i)
					begin
						if (dw_i == `CSFM_SCRATCH_IDX)
							rdata_d = scratch_q[slot];
						else if (dw_i == `CSFM_STICKY_IDX)
							rdata_d = sticky_q[slot];
						else if (dw_i >= `CSFM_PRIV_LO)
							rdata_d = `CSFM_PRIV_VALUE;
					end
					// writes outside the two dwords are dropped
					if (bus_hit && fn_hit && we_i)
					begin
						if (dw_i == `CSFM_SCRATCH_IDX)
							scratch_d[slot] = merge_be(scratch_q[slot],
								wdata_i, be_i);
						else if (dw_i == `CSFM_STICKY_IDX)
							sticky_d[slot] = merge_be(sticky_q[slot],
								wdata_i, be_i);
					end
				end
			end
			csfm_pkg::CSFM_RESP:
			begin
				// one idle turn between requests
				state_d = csfm_pkg::CSFM_IDLE;
			end
			default:
				state_d = csfm_pkg::CSFM_IDLE;
		endcase
		stat_d = sticky_q[0];
	end

	// hard reset: everything except sticky storage
	always_ff @(posedge clk_i)
	begin
		if (rst_i || power_good_reset_i)
		begin
			state_q      <= csfm_pkg::CSFM_IDLE;
			done_q       <= 1'b0;
			claim_q      <= 1'b0;
			rdata_q      <= 32'h0000_0000;
			strap_load_q <= 1'b1;
			bus_q        <= 8'hff;
			for (int i = 0; i < `CSFM_NFUNC; i++)
				scratch_q[i] <= `CSFM_SCRATCH_RST;
		end
		else
		begin
			state_q      <= state_d;
			done_q       <= done_d;
			claim_q      <= claim_d;
			rdata_q      <= rdata_d;
			strap_load_q <= strap_load_d;
			bus_q        <= bus_d;
			scratch_q    <= scratch_d;
		end
	end

	// sticky storage clears only on power-good reset
	always_ff @(posedge clk_i)
	begin
		if (power_good_reset_i)
		begin
			for (int i = 0; i < `CSFM_NFUNC; i++)
				sticky_q[i] <= `CSFM_STICKY_RST;
			stat_q <= `CSFM_STICKY_RST;
		end
		else if (rst_i)
		begin
			// hold through hard reset
			sticky_q <= sticky_q;
			stat_q   <= stat_q;
		end
		else
		begin
			sticky_q <= sticky_d;
			stat_q   <= stat_d;
		end
	end

	assign done_o          = done_q;
	assign claim_o         = claim_q;
	assign rdata_o         = rdata_q;
	assign bus_num_o       = bus_q;
	assign sticky_status_o = stat_q;

	// a request taken by the idle responder
	sequence take_s;
		req_i && state_q == csfm_pkg::CSFM_IDLE;
	endsequence

	// every request taken in idle answered next cycle
	req_done_a: assert property (@(posedge clk_i)
		disable iff (rst_i || power_good_reset_i)
		take_s |=> done_o)
		else $error("request not completed");

	// unclaimed or reserved reads give zero
	unused_bit_zero_a: assert property (@(posedge clk_i)
		disable iff (rst_i || power_good_reset_i)
		take_s ##0 (!we_i && (!bus_hit || !fn_hit
		|| (dw_i != `CSFM_SCRATCH_IDX && dw_i != `CSFM_STICKY_IDX
		&& dw_i < `CSFM_PRIV_LO)))
		|=> rdata_o == 32'h0000_0000)
		else $error("reserved read not zero");

	// reserved write leaves the function's storage alone
	unused_bit_write_a: assert property (@(posedge clk_i)
		disable iff (rst_i || power_good_reset_i)
		take_s ##0 (we_i && !strap_load_q
		&& dw_i != `CSFM_SCRATCH_IDX && dw_i != `CSFM_STICKY_IDX)
		|=> scratch_q[$past(slot)] == $past(scratch_q[slot])
		&& sticky_q[$past(slot)] == $past(sticky_q[slot]))
		else $error("reserved write changed state");

	// sticky survives hard reset
	sticky_hold_a: assert property (@(posedge clk_i)
		disable iff (power_good_reset_i)
		rst_i |=> sticky_q[0] == $past(sticky_q[0]))
		else $error("sticky lost on hard reset");

	// power-good clears sticky; not disabled, it is the reset itself
	sticky_clear_a: assert property (@(posedge clk_i)
		power_good_reset_i |=> sticky_q[0] == `CSFM_STICKY_RST)
		else $error("sticky not cleared");

	// absent link function 5 does not claim
	link_absent_a: assert property (@(posedge clk_i)
		disable iff (rst_i || power_good_reset_i)
		take_s ##0 (!two_links_i && dev_i == `CSFM_DEV_LINK
		&& fn_i == `CSFM_FN_L1_PHY)
		|=> done_o && !claim_o)
		else $error("absent link function claimed");

	// ras function follows rdimm option
	ras_claim_a: assert property (@(posedge clk_i)
		disable iff (rst_i || power_good_reset_i)
		take_s ##0 (bus_hit && dev_i == `CSFM_DEV_MC
		&& fn_i == `CSFM_FN_MC_RAS)
		|=> claim_o == $past(rdimm_i))
		else $error("ras claim wrong");

	// channel device 6 claims function 3
	chan_claim_a: assert property (@(posedge clk_i)
		disable iff (rst_i || power_good_reset_i)
		take_s ##0 (bus_hit && dev_i == `CSFM_DEV_CH2 && fn_i == 3'h3)
		|=> claim_o)
		else $error("channel function not claimed");

	// device 0 claims two functions
	unc_claim_a: assert property (@(posedge clk_i)
		disable iff (rst_i || power_good_reset_i)
		take_s ##0 (bus_hit && dev_i == `CSFM_DEV_UNCORE)
		|=> claim_o == ($past(fn_i) <= 3'h1))
		else $error("uncore claim wrong");
endmodule : csfm_config_space

// >>> tb/csfm_host.sv
`timescale 1ns/1ps
// host model: one configuration cycle at a time, request as a pulse
module csfm_host
(
	// clock
	input  wire logic        clk_i,
	// answer
	input  wire logic        done_i,
	input  wire logic        claim_i,
	input  wire logic [31:0] rdata_i,
	// request
	output logic             req_o,
	output logic             we_o,
	output logic [7:0]       bus_o,
	output logic [4:0]       dev_o,
	output logic [2:0]       fn_o,
	output logic [5:0]       dw_o,
	output logic [3:0]       be_o,
	output logic [31:0]      wdata_o
);
	logic [7:0]  tgt_bus = 8'hf5; // bus aimed at
	logic        claim_q;         // claim of last cycle
	logic [31:0] data_q;          // read data of last cycle
	logic        hung = 1'b0;     // no completion seen
	initial
	begin
		{req_o, we_o, bus_o, dev_o, fn_o, dw_o, be_o, wdata_o} = '0;
	end
	task access(input logic w, input logic [4:0] d, input logic [2:0] f,
		input logic [5:0] a, input logic [3:0] b, input logic [31:0] v);
		int n;
		// private dwords are never written from this side
		if (w && a >= 6'h38)
			return;
		@(posedge clk_i);
		#1;
		{req_o, we_o, bus_o, dev_o, fn_o, dw_o, be_o, wdata_o} =
			{1'b1, w, tgt_bus, d, f, a, b, v};
		@(posedge clk_i);
		#1;
		// released lines flip so a stale value never looks live
		{we_o, bus_o, dev_o, fn_o, dw_o, be_o, wdata_o} =
			~{we_o, bus_o, dev_o, fn_o, dw_o, be_o, wdata_o};
		req_o = 1'b0;
		n = 0;
		while (done_i !== 1'b1 && n < 4)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		hung = (done_i !== 1'b1);
		claim_q = claim_i;
		data_q = rdata_i;
	endtask : access
	// change masked bits only, leaving reserved positions as read
	task rmw(input logic [4:0] d, input logic [2:0] f, input logic [5:0] a,
		input logic [31:0] m, input logic [31:0] v);
		access(1'b0, d, f, a, 4'hf, 32'h0);
		access(1'b1, d, f, a, 4'hf, (data_q & ~m) | (v & m));
	endtask : rmw
endmodule : csfm_host

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] STRAP = 32'hc3a5_0f1e; // scratch default
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;    // hard reset, high at start
	logic        pg_i = 1'b1;     // power-good reset, high at start
	logic        two_links_i = 1'b0;
	logic        rdimm_i = 1'b0;
	logic [1:0]  rng = 2'h1;      // bus range strap
	logic [2:0]  sock = 3'h2;     // socket strap
	logic        req, we, done, claim;
	logic [7:0]  bus, bus_num;
	logic [4:0]  dev;
	logic [2:0]  fn;
	logic [5:0]  dw;
	logic [3:0]  be;
	logic [31:0] wdata, rdata, sticky;
	int          err_total = 0;
	int          checked = 0;
	int          cyc = 0;
	csfm_config_space csfm_config_space_i (.clk_i(clk_i), .rst_i(rst_i),
		.power_good_reset_i(pg_i), .max_bus_range_i(rng),
		.socket_id_i(sock), .scratch_strap_i(STRAP),
		.two_links_i(two_links_i), .rdimm_i(rdimm_i), .req_i(req),
		.we_i(we), .bus_i(bus), .dev_i(dev), .fn_i(fn), .dw_i(dw),
		.be_i(be), .wdata_i(wdata), .done_o(done), .claim_o(claim),
		.rdata_o(rdata), .bus_num_o(bus_num), .sticky_status_o(sticky));
	csfm_host csfm_host_i (.clk_i(clk_i), .done_i(done), .claim_i(claim),
		.rdata_i(rdata), .req_o(req), .we_o(we), .bus_o(bus), .dev_o(dev),
		.fn_o(fn), .dw_o(dw), .be_o(be), .wdata_o(wdata));
	// 100 MHz clock
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end
	// hang guard, well above the few hundred cycles needed
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			conclude();
		end
	end
	task chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk_w
	task do_reset(input logic p);
		@(posedge clk_i);
		#1;
		if (p)
			pg_i = 1'b1;
		else
			rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		pg_i = 1'b0;
	endtask : do_reset
	// presence of a function for the given part options
	function automatic logic present(int d, int f, logic o);
		case (d)
			0: return f < 2;
			2: return f < 2 || (o && (f == 4 || f == 5));
			3: return f == 0 || f == 1 || f == 4 || (o && f == 2);
			4, 5, 6: return f < 4;
			default: return 1'b0;
		endcase
	endfunction : present
	task t_decode;
		logic [31:0] e;
		logic [31:0] g;
		for (int c = 0; c < 2; c++)
		begin
			two_links_i = c[0];
			rdimm_i = c[0];
			for (int d = 0; d < 8; d++)
				for (int f = 0; f < 8; f++)
				begin
					csfm_host_i.access(1'b0, d[4:0], f[2:0], 6'h10,
						4'hf, 32'h0);
					e = {31'h0, present(d, f, c[0])};
					g = {31'h0, csfm_host_i.claim_q};
					chk_w("claim", e, g);
				end
		end
		chk_w("bus", 32'h0000_00f5, {24'h0, bus_num});
		csfm_host_i.tgt_bus = 8'hf4;
		csfm_host_i.access(1'b0, 5'h00, 3'h0, 6'h10, 4'hf, 32'h0);
		chk_w("foreign", 32'h0, {csfm_host_i.claim_q,
			csfm_host_i.data_q[30:0]});
		chk_w("foreign_done", 32'h0, {31'h0, csfm_host_i.hung});
		// other strap values move the claimed bus a cycle later
		rng = 2'h2;
		sock = 3'h5;
		@(posedge clk_i);
		#1;
		chk_w("bus_alt", 32'h0000_00ea, {24'h0, bus_num});
		csfm_host_i.tgt_bus = 8'hea;
		csfm_host_i.access(1'b0, 5'h06, 3'h3, 6'h10, 4'hf, 32'h0);
		chk_w("claim_alt", 32'h1, {31'h0, csfm_host_i.claim_q});
		rng = 2'h1;
		sock = 3'h2;
		csfm_host_i.tgt_bus = 8'hf5;
		$display("test decode done");
	endtask : t_decode
	task t_reserved;
		logic [3:0] bes [3] = '{4'h1, 4'h3, 4'hf};
		csfm_host_i.access(1'b1, 5'h04, 3'h3, 6'h20, 4'hf, 32'hffff_ffff);
		chk_w("hang", 32'h0, {31'h0, csfm_host_i.hung});
		foreach (bes[i])
		begin
			csfm_host_i.access(1'b0, 5'h04, 3'h3, 6'h20, bes[i], 32'h0);
			chk_w("rsv", 32'h0, csfm_host_i.data_q);
		end
		csfm_host_i.access(1'b0, 5'h04, 3'h3, 6'h10, 4'hf, 32'h0);
		chk_w("scratch", STRAP, csfm_host_i.data_q);
		csfm_host_i.access(1'b0, 5'h04, 3'h3, 6'h11, 4'hf, 32'h0);
		chk_w("sticky_rsv", 32'h0, csfm_host_i.data_q);
		csfm_host_i.access(1'b0, 5'h04, 3'h3, 6'h38, 4'hf, 32'h0);
		chk_w("priv", 32'h5a5a_0000, csfm_host_i.data_q);
		$display("test reserved done");
	endtask : t_reserved
	task t_sticky;
		csfm_host_i.rmw(5'h00, 3'h0, 6'h11, 32'h0000_ffff, 32'h0000_beef);
		// status output is a registered copy, one cycle behind the dword
		@(posedge clk_i);
		#1;
		chk_w("stk", 32'h0000_beef, sticky);
		csfm_host_i.access(1'b1, 5'h00, 3'h0, 6'h10, 4'h3, 32'h1234_5678);
		csfm_host_i.access(1'b0, 5'h00, 3'h0, 6'h10, 4'hf, 32'h0);
		chk_w("scr_be", 32'hc3a5_5678, csfm_host_i.data_q);
		do_reset(1'b0);
		chk_w("stk_hard", 32'h0000_beef, sticky);
		csfm_host_i.access(1'b0, 5'h00, 3'h0, 6'h11, 4'hf, 32'h0);
		chk_w("stk_rd", 32'h0000_beef, csfm_host_i.data_q);
		csfm_host_i.access(1'b0, 5'h00, 3'h0, 6'h10, 4'hf, 32'h0);
		chk_w("scr_def", STRAP, csfm_host_i.data_q);
		do_reset(1'b1);
		chk_w("stk_pg", 32'h0, sticky);
		$display("test sticky done");
	endtask : t_sticky
	task conclude;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (10) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		pg_i = 1'b0;
		t_decode();
		t_reserved();
		t_sticky();
		conclude();
	end
endmodule : tb
